// >>> rtl/bsc_pkg.sv
package bsc_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] BSC_OFF_RCP = 8'h00;
  localparam logic [7:0] BSC_OFF_BG = 8'h04;
  localparam logic [7:0] BSC_OFF_FG = 8'h08;
  localparam logic [7:0] BSC_OFF_INSTR = 8'h0c;
  localparam logic [7:0] BSC_OFF_DBASE = 8'h10;
  localparam logic [7:0] BSC_OFF_DWORK = 8'h14;

  // ==========================================================================
  // setup_raster_control_pitch fields
  localparam int BSC_F_SOLID = 31;
  localparam int BSC_F_CLIP = 30;
  localparam int BSC_F_SRC_TR = 29;
  localparam int BSC_F_PAT_TR = 28;
  localparam int BSC_F_MASK_A = 27;
  localparam int BSC_F_MASK_RGB = 26;
  localparam int BSC_F_DEPTH_HI = 25;
  localparam int BSC_F_DEPTH_LO = 24;
  localparam int BSC_F_ROP_HI = 23;
  localparam int BSC_F_ROP_LO = 16;
  localparam int BSC_F_PITCH_HI = 15;

  // ==========================================================================
  // instruction control fields
  localparam int BSC_I_SRC_MONO = 0;
  localparam int BSC_I_PAT_MONO = 1;
  localparam int BSC_I_COORD = 2;
  localparam int BSC_I_TILED = 3;
  localparam int BSC_I_KIND_HI = 5;
  localparam int BSC_I_KIND_LO = 4;
  localparam logic [1:0] BSC_KIND_SCANLINE = 2'h0;
  localparam logic [1:0] BSC_KIND_GLYPH = 2'h1;
  localparam logic [1:0] BSC_KIND_SINGLE_PIXEL = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [31:0] BSC_RST_RCP = 32'h0000_0000;
  localparam logic [31:0] BSC_RST_BG = 32'h0000_0000;
  localparam logic [31:0] BSC_RST_FG = 32'h0000_0000;
  localparam logic [31:0] BSC_RST_INSTR = 32'h0000_0000;

  // ==========================================================================
  // depth codes and decoded depth
  localparam logic [1:0] BSC_DEPTH_8 = 2'h0;
  localparam logic [1:0] BSC_DEPTH_16A = 2'h1;
  localparam logic [1:0] BSC_DEPTH_16B = 2'h2;
  localparam logic [1:0] BSC_DEPTH_32 = 2'h3;

  typedef enum logic [2:0]
  {
    BSC_BPP8 = 3'b001,
    BSC_BPP16 = 3'b010,
    BSC_BPP32 = 3'b100
  } bsc_bpp_t;

  typedef enum logic [1:0]
  {
    BSC_APB_IDLE = 2'b01,
    BSC_APB_ANSWER = 2'b10
  } bsc_apb_st_t;

endpackage

// >>> rtl/bsc_blit_setup.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
// Functional notes
// - mono source zero bit uses background, written
// - mono source zero bit, transparent: no write
// - mono pattern zero bit uses background, written
// - mono pattern transparent zero bit: no write
// - mask enables alpha and rgb at thirty_two_bits_per_pixel
// - depth 00=8, 01/10=16, 11=32 bpp
// - eight-bit code picks source/pattern/dest combination
// - non-coordinate pitch is signed byte count
// - tiled coordinate pitch counts doublewords, 512B aligned
// - linear coordinate pitch is signed bytes
// - pitch added to working address per line
// - one bit enables destination clipping
// - background register expands mono scanline/glyph data
// - background is solid pattern for single pixel
// - colours trimmed to 32/16/8 bits by depth
// - foreground register expands one-valued mono bits
// - solid pattern: pattern bits zero, background used
module bsc_blit_setup
  import bsc_pkg::*;
#(
  parameter int ADDR_W = 29
)
(
  input wire logic pclk, // bus and engine clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic pix_valid, // one pixel of operands present
  input wire logic src_bit, // monochrome source bit
  input wire logic [31:0] src_color, // colour source pixel
  input wire logic pat_bit, // monochrome pattern bit
  input wire logic [31:0] pat_color, // colour pattern pixel
  input wire logic [31:0] dst_data, // current destination pixel
  input wire logic clip_inside, // pixel lies inside clip rectangle
  input wire logic line_done, // pulse, one scan line written
  output logic wr_valid, // result pixel valid, one-cycle pulse
  output logic [31:0] wr_data, // result pixel
  output logic [3:0] wr_be, // destination byte write enables
  output logic pat_fetch_en, // pattern reads needed
  output logic [ADDR_W-1:0] dst_addr // working destination address
);

  // ==========================================================================
  // elaboration check
  if (ADDR_W < 18 || ADDR_W > 32)
  begin
    $error("ADDR_W must lie in 18..32 to hold a doubleword-scaled pitch");
  end

  // ==========================================================================
  // functions
  function automatic bsc_bpp_t depth_decode(input logic [1:0] code);
    bsc_bpp_t r;
    case (code)
      BSC_DEPTH_8: r = BSC_BPP8;
      BSC_DEPTH_16A: r = BSC_BPP16;
      BSC_DEPTH_16B: r = BSC_BPP16;
      BSC_DEPTH_32: r = BSC_BPP32;
      default: r = BSC_BPP8;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] depth_trim(input bsc_bpp_t bpp, input logic [31:0] c);
    logic [31:0] r;
    case (bpp)
      BSC_BPP8: r = {24'h00_0000, c[7:0]};
      BSC_BPP16: r = {16'h0000, c[15:0]};
      BSC_BPP32: r = c;
      default: r = c;
    endcase
    return r;
  endfunction

  // expand a monochrome bit to foreground or background colour
  function automatic logic [31:0] expand(input logic bitv, input logic [31:0] fg, input logic [31:0] bg);
    return bitv ? fg : bg;
  endfunction

  // each result bit is the code bit indexed by {pattern, source, destination}
  function automatic logic [31:0] rop_apply(input logic [7:0] code, input logic [31:0] p,
                                            input logic [31:0] s, input logic [31:0] d);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      r[i] = code[{p[i], s[i], d[i]}];
    end
    return r;
  endfunction

  // ==========================================================================
  // registers
  logic [31:0] rcp_q;
  logic [31:0] rcp_d;
  logic [31:0] bg_q;
  logic [31:0] bg_d;
  logic [31:0] fg_q;
  logic [31:0] fg_d;
  logic [31:0] instr_q;
  logic [31:0] instr_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  bsc_apb_st_t apb_q;
  bsc_apb_st_t apb_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  logic wr_valid_q;
  logic [31:0] wr_data_q;
  logic [31:0] wr_data_d;
  logic [3:0] wr_be_q;
  logic [3:0] wr_be_d;
  logic pat_fetch_q;

  // ==========================================================================
  // apb decode
  wire logic setup_phase = psel && !penable && (apb_q == BSC_APB_IDLE);
  wire logic commit = psel && penable && (apb_q == BSC_APB_ANSWER);
  wire logic hit_rcp = (paddr == BSC_OFF_RCP);
  wire logic hit_bg = (paddr == BSC_OFF_BG);
  wire logic hit_fg = (paddr == BSC_OFF_FG);
  wire logic hit_instr = (paddr == BSC_OFF_INSTR);
  wire logic hit_dbase = (paddr == BSC_OFF_DBASE);
  wire logic hit_dwork = (paddr == BSC_OFF_DWORK);
  wire logic mapped = hit_rcp || hit_bg || hit_fg || hit_instr || hit_dbase || hit_dwork;
  wire logic wr_ok = commit && pwrite && mapped;

  wire logic [31:0] addr_word = {{(32 - ADDR_W){1'b0}}, addr_q};
  wire logic [31:0] rd_mux =
    hit_rcp ? rcp_q :
    hit_bg ? bg_q :
    hit_fg ? fg_q :
    hit_instr ? instr_q :
    (hit_dbase || hit_dwork) ? addr_word :
    32'h0000_0000;

  assign apb_d = setup_phase ? BSC_APB_ANSWER : (commit ? BSC_APB_IDLE : apb_q);
  assign prdata_d = (setup_phase && !pwrite) ? rd_mux : prdata_q;
  assign pslverr_d = setup_phase && !mapped;

  assign rcp_d = (wr_ok && hit_rcp) ? pwdata : rcp_q;
  assign bg_d = (wr_ok && hit_bg) ? pwdata : bg_q;
  assign fg_d = (wr_ok && hit_fg) ? pwdata : fg_q;
  assign instr_d = (wr_ok && hit_instr) ? pwdata : instr_q;

  // ==========================================================================
  // field decode
  wire logic solid_sel = rcp_q[BSC_F_SOLID];
  wire logic clip_en = rcp_q[BSC_F_CLIP];
  wire logic src_trans = rcp_q[BSC_F_SRC_TR];
  wire logic pat_trans = rcp_q[BSC_F_PAT_TR];
  wire logic mask_alpha = rcp_q[BSC_F_MASK_A];
  wire logic mask_rgb = rcp_q[BSC_F_MASK_RGB];
  wire logic [1:0] depth_code = rcp_q[BSC_F_DEPTH_HI:BSC_F_DEPTH_LO];
  wire logic [7:0] rop_code = rcp_q[BSC_F_ROP_HI:BSC_F_ROP_LO];
  wire logic [15:0] pitch = rcp_q[BSC_F_PITCH_HI:0];
  wire logic src_mono = instr_q[BSC_I_SRC_MONO];
  wire logic pat_mono = instr_q[BSC_I_PAT_MONO];
  wire logic coord_blit = instr_q[BSC_I_COORD];
  wire logic dst_tiled = instr_q[BSC_I_TILED];
  wire logic [1:0] kind = instr_q[BSC_I_KIND_HI:BSC_I_KIND_LO];
  wire bsc_bpp_t bpp = depth_decode(depth_code);

  // ==========================================================================
  // operand selection
  wire logic single_pixel = (kind == BSC_KIND_SINGLE_PIXEL);
  wire logic solid_pat = pat_mono && solid_sel;
  // a solid pattern reads as all zero bits
  wire logic pat_bit_eff = solid_pat ? 1'b0 : pat_bit;
  wire logic [31:0] src_op = src_mono ? expand(src_bit, fg_q, bg_q) : src_color;
  wire logic [31:0] pat_mono_op = expand(pat_bit_eff, fg_q, bg_q);
  wire logic [31:0] pat_any = pat_mono ? pat_mono_op : pat_color;
  wire logic [31:0] pat_op = single_pixel ? bg_q : pat_any;
  // F0 copies the pattern bits; the opcode check is the issuer's job
  wire logic [31:0] rop_out = rop_apply(rop_code, depth_trim(bpp, pat_op),
                                        depth_trim(bpp, src_op), dst_data);

  // ==========================================================================
  // byte write enables
  wire logic [3:0] depth_be =
    (bpp == BSC_BPP8) ? 4'h1 :
    (bpp == BSC_BPP16) ? 4'h3 :
    {mask_alpha, {3{mask_rgb}}};
  // transparency only applies to monochrome operands
  wire logic src_hide = src_mono && src_trans && !src_bit;
  wire logic pat_hide = pat_mono && pat_trans && !pat_bit_eff;
  wire logic clip_hide = clip_en && !clip_inside;
  wire logic pixel_hide = src_hide || pat_hide || clip_hide;

  assign wr_data_d = pix_valid ? rop_out : wr_data_q;
  assign wr_be_d = pix_valid ? (pixel_hide ? 4'h0 : depth_be) : 4'h0;

  // ==========================================================================
  // destination pitch stepping
  // pitch is scaled to doublewords only for coordinate blits on tiled surfaces
  wire logic dword_pitch = coord_blit && dst_tiled;
  wire logic [ADDR_W-1:0] pitch_bytes = {{(ADDR_W - 16){pitch[15]}}, pitch};
  wire logic [ADDR_W-1:0] pitch_dw = {{(ADDR_W - 18){pitch[15]}}, pitch, 2'b00};
  wire logic [ADDR_W-1:0] pitch_step = dword_pitch ? pitch_dw : pitch_bytes;
  // modular add wraps like two's complement, so negative pitch walks downward in memory
  wire logic [ADDR_W-1:0] addr_next = addr_q + pitch_step;
  // a software load of the base wins over a line step in the same cycle
  assign addr_d = (wr_ok && hit_dbase) ? pwdata[ADDR_W-1:0] :
                  (line_done ? addr_next : addr_q);

  wire logic pat_fetch_d = !pat_mono || !solid_sel;

  // ==========================================================================
  // setup register file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcp_q <= BSC_RST_RCP;
      bg_q <= BSC_RST_BG;
      fg_q <= BSC_RST_FG;
      instr_q <= BSC_RST_INSTR;
    end
    else if (ce)
    begin
      rcp_q <= rcp_d;
      bg_q <= bg_d;
      fg_q <= fg_d;
      instr_q <= instr_d;
    end
  end

  // ==========================================================================
  // working destination address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q <= '0;
    end
    else if (ce)
    begin
      addr_q <= addr_d;
    end
  end

  // ==========================================================================
  // apb state
  // ce low stretches the access phase, so pready may stand longer than one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_q <= BSC_APB_IDLE;
    end
    else if (ce)
    begin
      apb_q <= apb_d;
    end
  end

  // ==========================================================================
  // apb response
  // the error flag lives only for the access cycle, like pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================================
  // pixel result
  // hidden pixels still pulse wr_valid so a consumer can count pixels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_valid_q <= 1'b0;
      wr_data_q <= 32'h0000_0000;
      wr_be_q <= 4'h0;
    end
    else if (ce)
    begin
      wr_valid_q <= pix_valid;
      wr_data_q <= wr_data_d;
      wr_be_q <= wr_be_d;
    end
  end

  // ==========================================================================
  // pattern fetch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pat_fetch_q <= 1'b1;
    end
    else if (ce)
    begin
      pat_fetch_q <= pat_fetch_d;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = prdata_q;
  // one-hot state: bit 1 is the answer state, so pready is a flop output
  assign pready = apb_q[1];
  assign pslverr = pslverr_q;
  assign wr_valid = wr_valid_q;
  assign wr_data = wr_data_q;
  assign wr_be = wr_be_q;
  assign pat_fetch_en = pat_fetch_q;
  assign dst_addr = addr_q;

endmodule

// >>> tb/bsc_blit_setup_sva.sv
`timescale 1ns/100ps
module bsc_blit_setup_chk
  import bsc_pkg::*;
#(
  parameter int ADDR_W = 29
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic ce, // enable
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic pix_valid, // pixel in
  input wire logic line_done, // line step
  input wire logic wr_valid, // pixel out
  input wire logic [3:0] wr_be, // enables
  input wire logic [ADDR_W-1:0] dst_addr // work address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a bus write of the base register may move the address without a line step
  wire base_wr = pready && psel && pwrite && paddr == BSC_OFF_DBASE;
  // ==========================================================================
  // bus
  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  a_mapped_no_err: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  // ==========================================================================
  // pixel path
  a_pix_answer: assert property (ce && pix_valid |=> wr_valid)
    else $error("no result after pixel");
  a_pix_cause: assert property (wr_valid |-> $past(pix_valid))
    else $error("result without pixel");
  a_be_idle: assert property (!wr_valid |-> wr_be == 4'h0)
    else $error("byte enables without result");
  a_addr_hold: assert property (!line_done && !base_wr |=> $stable(dst_addr))
    else $error("address moved without line step");
endmodule
bind bsc_blit_setup bsc_blit_setup_chk #(.ADDR_W(ADDR_W)) bsc_blit_setup_chk_inst (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pix_valid(pix_valid), .line_done(line_done), .wr_valid(wr_valid), .wr_be(wr_be), .dst_addr(dst_addr));

// >>> tb/bsc_cmd_streamer.sv
`timescale 1ns/100ps
module bsc_cmd_streamer
  import bsc_pkg::*;
(
  input wire logic pclk, // clock
  output logic psel, // select
  output logic penable, // access
  output logic pwrite, // write
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  logic err;
  int gap = 0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // ==========================================================================
  // one transfer, held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not keep showing the last word
    pwdata <= ~d;
  endtask
  // ==========================================================================
  // setup instruction: instruction word first, then raster word with the opcode
  task setup(input logic [31:0] rcp, input logic [31:0] ins);
    logic [31:0] q;
    if (rcp[23:16] == 8'hf0)
      ins[BSC_I_SRC_MONO] = 1'b1;
    xfer(1'b1, BSC_OFF_INSTR, ins, q);
    xfer(1'b1, BSC_OFF_RCP, rcp, q);
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) \
  begin $display("BAD %s exp %h got %h", n, e, g); err_count++; end end
`define W(a, d) bsc_cmd_streamer_inst.xfer(1'b1, a, d, q);
`define R(a) bsc_cmd_streamer_inst.xfer(1'b0, a, 32'h0, q);
`define S(r, i) bsc_cmd_streamer_inst.setup(r, i);
module testbench;
  import bsc_pkg::*;
  localparam logic [31:0] BG = 32'h8844_2211;
  localparam logic [31:0] FG = 32'h77bb_ddee;
  localparam logic [31:0] PC = 32'hf0f0_3c3c;
  localparam logic [31:0] DD = 32'h0ff0_6699;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, pix_valid, src_bit, pat_bit, clip_inside;
  logic line_done, wr_valid, pat_fetch_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, src_color, wr_data, q;
  logic [3:0] wr_be;
  logic [28:0] dst_addr;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  bsc_blit_setup bsc_blit_setup_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .src_bit(src_bit), .src_color(src_color), .pat_bit(pat_bit), .pat_color(PC),
    .dst_data(DD), .clip_inside(clip_inside), .line_done(line_done), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_be(wr_be), .pat_fetch_en(pat_fetch_en), .dst_addr(dst_addr));
  bsc_cmd_streamer bsc_cmd_streamer_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] rop_ref(input logic [7:0] r, input logic [31:0] s);
    logic [31:0] f;
    for (int i = 0; i < 32; i++)
      f[i] = r[{PC[i], s[i], DD[i]}];
    return f;
  endfunction
  task pix(input logic sb, input logic pb, input logic [31:0] sc, input logic [31:0] ed, input logic [3:0] eb);
    @(posedge pclk);
    {pix_valid, src_bit, pat_bit, src_color} <= {1'b1, sb, pb, sc};
    @(posedge pclk);
    pix_valid <= 1'b0;
    @(negedge pclk);
    `CHK("wr_valid", 1'b1, wr_valid)
    // data of a suppressed pixel is never stored, so it is not judged
    if (eb != 4'h0)
      `CHK("wr_data", ed, wr_data)
    `CHK("wr_be", eb, wr_be)
  endtask
  task step(input logic [28:0] e);
    @(posedge pclk);
    line_done <= 1'b1;
    @(posedge pclk);
    line_done <= 1'b0;
    @(negedge pclk);
    `CHK("dst_addr", e, dst_addr)
  endtask
  task tally_and_finish;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task t_regs;
    bsc_cmd_streamer_inst.gap = 2;
    `R(BSC_OFF_RCP) `CHK("rcp reset", BSC_RST_RCP, q)
    `R(BSC_OFF_BG) `CHK("bg reset", BSC_RST_BG, q)
    `W(BSC_OFF_BG, BG) `W(BSC_OFF_FG, FG) `R(BSC_OFF_FG) `CHK("fg rw", FG, q)
    `R(8'h40) `CHK("unmapped", 1'b1, bsc_cmd_streamer_inst.err)
    bsc_cmd_streamer_inst.gap = 0;
  endtask
  task t_src;
    `S(32'h0fcc_0000, 32'h1) pix(1'b1, 1'b0, 32'h0, FG, 4'hf);
    pix(1'b0, 1'b0, 32'h0, BG, 4'hf);
    `S(32'h2fcc_0000, 32'h1) pix(1'b0, 1'b0, 32'h0, BG, 4'h0);
    pix(1'b1, 1'b0, 32'h0, FG, 4'hf);
    `S(32'h3fcc_0000, 32'h0) pix(1'b0, 1'b0, 32'h1234_5678, 32'h1234_5678, 4'hf);
  endtask
  task t_pat;
    `S(32'h0ff0_0000, 32'h2) pix(1'b0, 1'b1, 32'h0, FG, 4'hf);
    pix(1'b0, 1'b0, 32'h0, BG, 4'hf);
    `S(32'h1ff0_0000, 32'h2) pix(1'b0, 1'b0, 32'h0, BG, 4'h0);
    pix(1'b0, 1'b1, 32'h0, FG, 4'hf);
    `S(32'h8ff0_0000, 32'h2) pix(1'b0, 1'b1, 32'h0, BG, 4'hf);
    `CHK("pat_fetch_en", 1'b0, pat_fetch_en)
    `S(32'h0ff0_0000, 32'h20) pix(1'b0, 1'b1, 32'h0, BG, 4'hf);
    `CHK("pat_fetch_en", 1'b1, pat_fetch_en)
  endtask
  task t_depth;
    logic [31:0] ed;
    logic [3:0] eb;
    for (int c = 0; c < 4; c++)
    begin
      `S({6'h02, 2'(c), 8'hcc, 16'h0}, 32'h1)
      ed = c == 0 ? FG & 32'hff : c < 3 ? FG & 32'hffff : FG;
      eb = c == 0 ? 4'h1 : c < 3 ? 4'h3 : 4'h8;
      pix(1'b1, 1'b0, 32'h0, ed, eb);
    end
    `S(32'h07cc_0000, 32'h1) pix(1'b1, 1'b0, 32'h0, FG, 4'h7);
  endtask
  task t_rop;
    for (int r = 0; r < 256; r += 51)
    begin
      `S({8'h0f, 8'(r), 16'h0}, 32'h0)
      pix(1'b0, 1'b0, 32'h3c69_a55a, rop_ref(8'(r), 32'h3c69_a55a), 4'hf);
    end
  endtask
  task t_clip;
    `S(32'h4fcc_0000, 32'h0) clip_inside <= 1'b0;
    pix(1'b0, 1'b0, 32'h1, 32'h1, 4'h0);
    clip_inside <= 1'b1;
    pix(1'b0, 1'b0, 32'h2, 32'h2, 4'hf);
    `S(32'h0fcc_0000, 32'h0) clip_inside <= 1'b0;
    pix(1'b0, 1'b0, 32'h3, 32'h3, 4'hf);
  endtask
  task t_pitch;
    `S(32'h0fcc_ff00, 32'h0) `W(BSC_OFF_DBASE, 32'h1000) step(29'h0f00);
    `S(32'h0fcc_0200, 32'h4) step(29'h1100);
    // tiled pitch of -512 dwords steps the address down by 2048 bytes
    `S(32'h0fcc_fe00, 32'hc) step(29'h0900);
    `S(32'h0fcc_0100, 32'h8) step(29'h0a00);
    `R(BSC_OFF_DWORK) `CHK("work addr", 32'h0a00, q)
  endtask
  // with ce low a pixel and a line step must both be ignored
  task t_ce;
    @(posedge pclk);
    ce <= 1'b0;
    {pix_valid, line_done} <= 2'b11;
    @(posedge pclk);
    {ce, pix_valid, line_done} <= 3'b100;
    @(negedge pclk);
    `CHK("frozen wr_valid", 1'b0, wr_valid)
    `CHK("frozen dst_addr", 29'h0a00, dst_addr)
  endtask
  // ==========================================================================
  // clock, reset, sequence, hang guard
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    {presetn, pix_valid, src_bit, pat_bit, line_done, src_color} = '0;
    {ce, clip_inside} = 2'b11;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_src;
    t_pat;
    t_depth;
    t_rop;
    t_clip;
    t_pitch;
    t_ce;
    tally_and_finish;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
endmodule
